// ===== rtl/tw_core.sv
// Two-wire master (write transfers) and address-matching slave with wake.
// Assumes open-drain pins resolved outside; oe_n low means pulling the line low.
//
// Contract
// - NAK with bytes left raises master idle flag at once, before STOP.
// - Master disable releases clock and data lines high immediately.
// - Bus alert input counts as asserted when high.
// - Deep sleep right after Start: no wake on address match, request NACKed.
`timescale 1ns/1ps
`default_nettype none
`include "tw_regs.svh"
module tw_core
  import tw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic mst_enable,
  input wire logic master_disable_bit,
  input wire logic mst_go,
  input wire logic [`TW_ADDR_W-1:0] mst_addr,
  input wire logic [`TW_CNT_W-1:0] mst_count,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic master_idle_flag,
  output logic mst_nak,
  output logic mst_alert,
  output logic serial_clock_line_o,
  output logic serial_clock_line_oe_n,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe_n,
  input wire logic bus_alert_input,
  input wire logic [`TW_ADDR_W-1:0] slv_addr,
  input wire logic sleep_deep,
  input wire logic slv_scl_i,
  input wire logic slv_sda_i,
  output logic slv_sda_o,
  output logic slv_sda_oe_n,
  output logic slv_match,
  output logic slv_wake
);

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  logic [`TW_SYNC_W-1:0] pins_s;
  logic s_scl_d_r, s_sda_d_r;

  tw_sync #(.W(`TW_SYNC_W)) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    // Alert enters inverted so that every bit resets to its pin's idle level
    .d({slv_sda_i, slv_scl_i, ~bus_alert_input, serial_data_line_i}),
    .q(pins_s)
  );

  wire m_sda = pins_s[`TW_SY_MSDA];
  wire alert_s = ~pins_s[`TW_SY_ALERT];
  wire s_scl = pins_s[`TW_SY_SSCL];
  wire s_sda = pins_s[`TW_SY_SSDA];
  wire s_start = s_scl & s_scl_d_r & s_sda_d_r & ~s_sda;
  wire s_stop = s_scl & s_scl_d_r & ~s_sda_d_r & s_sda;
  wire s_rise = s_scl & ~s_scl_d_r;
  wire s_fall = ~s_scl & s_scl_d_r;

  // ----------------------------------------
  // Quarter-bit tick divider
  // ----------------------------------------
  logic [`TW_DIV_W-1:0] div_r;
  wire tick = (div_r == `TW_DIV_W'(`TW_QTR_CYC - 1));

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      div_r <= '0;
    else
      div_r <= tick ? '0 : div_r + `TW_DIV_W'(1);
  end

  // ----------------------------------------
  // Master sequencer
  // ----------------------------------------
  tw_mst_st_t m_st_r, m_st_nxt;
  logic [1:0] ph_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;
  logic [`TW_CNT_W-1:0] rem_r;
  logic en_r, ack_bit_r, m_hold_r;

  wire ph_end = tick & (ph_r == `TW_PH_LAST);
  wire nak_seen = (m_st_r == M_ACK) & ph_end & ack_bit_r;
  wire load_byte = (m_st_r == M_ACK) & ph_end & ~ack_bit_r & (rem_r != '0) & tx_valid;
  wire ack_wait = (m_st_r == M_ACK) & ph_end & ~ack_bit_r & (rem_r != '0) & ~tx_valid;

  always_comb
  begin
    m_st_nxt = m_st_r;
    unique case (m_st_r)
      M_IDLE: if (mst_go && en_r) m_st_nxt = M_START;
      M_START: if (ph_end) m_st_nxt = M_SHIFT;
      M_SHIFT: if (ph_end && bit_r == '0) m_st_nxt = M_ACK;
      M_ACK:
        if (ph_end && !ack_wait)
          m_st_nxt = load_byte ? M_SHIFT : M_STOP;
      M_STOP: if (ph_end) m_st_nxt = M_IDLE;
      default: m_st_nxt = M_IDLE;
    endcase
  end

  // Clock low in phases 0-1, released in 2-3 (in STOP released from phase 1); STOP lifts data as its last phase ends, on entry to IDLE
  // Clock stays low while waiting for the next data byte
  wire scl_low_nxt = ((m_st_nxt == M_SHIFT || m_st_nxt == M_ACK || m_st_nxt == M_STOP) &
                     (tick ? (ph_r == `TW_PH_LAST || ph_r == 2'h0) : (ph_r <= 2'h1)) &
                     (m_st_nxt != M_STOP || m_st_r != M_STOP || ph_r == 2'h0 ||
                      (ph_r == `TW_PH_LAST))) |
                     (m_hold_r & (m_st_nxt == M_ACK));
  // Data moves one cycle after the clock falls; only from ACK into the next byte does it go low at the same edge
  wire sda_low_nxt = (m_st_nxt == M_START) |
                     ((m_st_nxt == M_SHIFT) & (m_st_r == M_START)) |
                     ((m_st_nxt == M_SHIFT) & (m_st_r != M_START) & ~sh_r[7]) |
                     ((m_st_nxt == M_ACK) & (m_st_r == M_SHIFT) & ~sh_r[7]) |
                     ((m_st_nxt == M_STOP) & (m_st_r == M_STOP));

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      m_st_r <= M_IDLE;
      en_r <= 1'b0;
      ph_r <= '0;
      bit_r <= '0;
      sh_r <= '0;
      rem_r <= '0;
      ack_bit_r <= 1'b0;
      m_hold_r <= 1'b0;
    end
    else if (master_disable_bit)
    begin
      m_st_r <= M_IDLE;
      m_hold_r <= 1'b0;
      en_r <= 1'b0;
      ph_r <= '0;
    end
    else
    begin
      m_st_r <= m_st_nxt;
      m_hold_r <= ack_wait | (m_hold_r & (m_st_nxt == M_ACK));
      if (mst_enable)
        en_r <= 1'b1;
      if (m_st_r == M_IDLE)
        ph_r <= '0;
      else if (tick && !ack_wait)
        ph_r <= ph_r + 2'h1;
      if (m_st_r == M_IDLE && mst_go && en_r)
      begin
        sh_r <= {mst_addr, `TW_WR_BIT};
        rem_r <= mst_count;
        bit_r <= `TW_BIT_LAST;
      end
      else if (m_st_r == M_SHIFT && ph_end)
      begin
        sh_r <= {sh_r[6:0], 1'b0};
        bit_r <= bit_r - 3'h1;
      end
      else if (load_byte)
      begin
        sh_r <= tx_data;
        rem_r <= rem_r - `TW_CNT_W'(1);
        bit_r <= `TW_BIT_LAST;
      end
      if (m_st_r == M_ACK && tick && ph_r == `TW_PH_SAMPLE)
        ack_bit_r <= m_sda;
    end
  end

  // ----------------------------------------
  // Master outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      serial_clock_line_oe_n <= 1'b1;
      serial_data_line_oe_n <= 1'b1;
      serial_clock_line_o <= 1'b0;
      serial_data_line_o <= 1'b0;
      master_idle_flag <= 1'b1;
      mst_nak <= 1'b0;
      tx_ready <= 1'b0;
      mst_alert <= 1'b0;
    end
    else
    begin
      serial_clock_line_oe_n <= master_disable_bit | ~scl_low_nxt;
      serial_data_line_oe_n <= master_disable_bit | ~sda_low_nxt;
      mst_alert <= alert_s;
      tx_ready <= load_byte & ~master_disable_bit;
      mst_nak <= nak_seen & ~master_disable_bit;
      if (master_disable_bit || (m_st_nxt == M_IDLE))
        master_idle_flag <= 1'b1;
      else if (nak_seen && rem_r != '0)
        master_idle_flag <= 1'b1;
      else if (m_st_r == M_IDLE && m_st_nxt == M_START)
        master_idle_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Slave address match and wake
  // ----------------------------------------
  tw_slv_st_t s_st_r;
  logic [3:0] s_cnt_r;
  logic [7:0] s_sh_r;
  logic s_deep_r;
  wire s_hit = (s_sh_r[7:1] == slv_addr);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_st_r <= S_IDLE;
      s_cnt_r <= '0;
      s_sh_r <= '0;
      s_deep_r <= 1'b0;
      s_scl_d_r <= 1'b1;
      s_sda_d_r <= 1'b1;
      slv_sda_o <= 1'b0;
      slv_sda_oe_n <= 1'b1;
      slv_match <= 1'b0;
      slv_wake <= 1'b0;
    end
    else
    begin
      s_scl_d_r <= s_scl;
      s_sda_d_r <= s_sda;
      slv_wake <= 1'b0;
      if (s_start)
      begin
        s_st_r <= S_ADDR;
        s_cnt_r <= '0;
        s_deep_r <= sleep_deep;
        slv_sda_oe_n <= 1'b1;
        slv_match <= 1'b0;
      end
      else if (s_stop)
      begin
        s_st_r <= S_IDLE;
        slv_sda_oe_n <= 1'b1;
      end
      else
      begin
        unique case (s_st_r)
          S_IDLE: s_cnt_r <= '0;
          S_ADDR:
          begin
            s_deep_r <= s_deep_r | sleep_deep;
            if (s_rise)
            begin
              s_sh_r <= {s_sh_r[6:0], s_sda};
              s_cnt_r <= s_cnt_r + 4'h1;
            end
            if (s_fall && s_cnt_r == `TW_SBIT_ACK)
            begin
              s_st_r <= S_ACK;
              slv_sda_oe_n <= ~s_hit | s_deep_r;
              slv_match <= s_hit & ~s_deep_r;
              slv_wake <= s_hit & ~s_deep_r;
            end
          end
          S_ACK:
            if (s_fall)
            begin
              s_st_r <= S_WAIT;
              slv_sda_oe_n <= 1'b1;
            end
          S_WAIT: s_cnt_r <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_nak_idle_early: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (nak_seen && rem_r != '0 && !master_disable_bit) |=> master_idle_flag && m_st_r == M_STOP)
    else $error("idle flag not raised at once on NAK");

  a_disable_release: assert property (@(posedge clk_sys) disable iff (!arst_n)
    master_disable_bit |=> serial_clock_line_oe_n && serial_data_line_oe_n && m_st_r == M_IDLE)
    else $error("lines not released after disable");

  a_alert_high: assert property (@(posedge clk_sys) disable iff (!arst_n)
    bus_alert_input [*3] |=> mst_alert)
    else $error("alert not taken as active high");

  a_deep_nack: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (s_st_r == S_ADDR && s_deep_r && s_fall && s_cnt_r == `TW_SBIT_ACK && !s_start && !s_stop)
    |=> slv_sda_oe_n && !slv_wake && !slv_match)
    else $error("slave acked or woke in deep sleep");

  a_nak_stop: assert property (@(posedge clk_sys)
    disable iff (!arst_n || master_disable_bit)
    nak_seen |=> (m_st_r == M_STOP) ##[1:600] ($rose(serial_data_line_oe_n) &&
    serial_clock_line_oe_n))
    else $error("no STOP after NAK");

  c_master_write: cover property (@(posedge clk_sys) disable iff (!arst_n) load_byte);
  c_master_nak: cover property (@(posedge clk_sys) disable iff (!arst_n)
    nak_seen && rem_r != '0);
  c_slave_wake: cover property (@(posedge clk_sys) disable iff (!arst_n) slv_wake);

endmodule
`default_nettype wire

// ===== rtl/tw_regs.svh
// Constants for the two-wire master/slave core: timing, widths, pin slots.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef TW_REGS_SVH
`define TW_REGS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define TW_CLK_NS 20
`define TW_QTR_NS 2500
`define TW_QTR_CYC ((`TW_QTR_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)
`define TW_DIV_W 8

// ----------------------------------------
// Widths, counts and pin slots
// ----------------------------------------
`define TW_ADDR_W 7
`define TW_CNT_W 8
`define TW_BIT_LAST 3'h7
`define TW_SBIT_ACK 4'h8
`define TW_PH_LAST 2'h3
`define TW_PH_SAMPLE 2'h2
`define TW_WR_BIT 1'h0
`define TW_SYNC_W 4
`define TW_SY_MSDA 0
`define TW_SY_ALERT 1
`define TW_SY_SSCL 2
`define TW_SY_SSDA 3

`endif

// ===== rtl/tw_pkg.sv
// Types for the two-wire master/slave core.
// Assumes tw_regs.svh supplies all numeric constants.
package tw_pkg;

  typedef enum logic [2:0] {M_IDLE, M_START, M_SHIFT, M_ACK, M_STOP} tw_mst_st_t;

  typedef enum logic [1:0] {S_IDLE, S_ADDR, S_ACK, S_WAIT} tw_slv_st_t;

endpackage

// ===== rtl/tw_sync.sv
// Two-flop synchroniser for a vector of pin inputs.
// Assumes each bit is an independent level from outside the clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module tw_sync #(
  parameter int W = 4
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // Ones: the idle level of a released two-wire line
      meta_r <= '1;
      q <= '1;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tw_peer_model.sv
// Behavioural bus slave on the master's lines: acks a set number of bytes.
// Assumes open-drain lines with pull-ups resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module tw_peer_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] ack_bytes,
  output logic sda_oe_n,
  output logic [7:0] first_byte,
  output int stops
);
  int bitn = 0;
  int nbyte = 0;
  bit in_ack = 1'h0;
  logic [7:0] sh = 8'h00;
  initial sda_oe_n = 1'h1;
  initial first_byte = 8'h00;
  initial stops = 0;
  // Start restarts byte framing
  always @(negedge sda)
    if (scl === 1'h1)
    begin
      bitn = 0;
      nbyte = 0;
      in_ack = 1'h0;
    end
  always @(posedge sda)
    if (scl === 1'h1)
      stops++;
  always @(posedge scl)
    if (bitn < 8)
    begin
      sh = {sh[6:0], sda};
      bitn++;
    end
  // Answer after the eighth bit; drop the answer on the next fall
  always @(negedge scl)
    if (in_ack)
    begin
      sda_oe_n = 1'h1;
      in_ack = 1'h0;
      bitn = 0;
      nbyte++;
    end
    else if (bitn == 8)
    begin
      in_ack = 1'h1;
      if (nbyte == 0)
        first_byte = sh;
      sda_oe_n = (nbyte >= ack_bytes);
    end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Bench for the two-wire core: master lines face a peer slave model,
// slave pins are driven here with a 160 ns link clock. Needs tw_peer_model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  logic mst_enable = 1'h0, master_disable_bit = 1'h0, mst_go = 1'h0, tx_valid = 1'h0;
  logic [6:0] mst_addr = 7'h00;
  logic [7:0] mst_count = 8'h00, tx_data = 8'hc3, ack_bytes = 8'h00, first_byte;
  logic bus_alert_input = 1'h0, sleep_deep = 1'h0, s_scl = 1'h1, s_sda = 1'h1;
  logic tx_ready, master_idle_flag, mst_nak, mst_alert, scl_oe_n, sda_oe_n;
  logic slv_sda_oe_n, slv_match, slv_wake, p_oe_n;
  logic scl_o, sda_o, slv_o;
  int stops, n_nak = 0, n_rdy = 0, n_wake = 0, mismatches = 0, n_compared = 0;
  wire logic sda_m = sda_oe_n & p_oe_n;
  wire logic sda_s = s_sda & slv_sda_oe_n;

  tw_core dut_u (.clk_sys, .arst_n, .mst_enable, .master_disable_bit, .mst_go, .mst_addr,
    .mst_count, .tx_data, .tx_valid, .tx_ready, .master_idle_flag, .mst_nak, .mst_alert,
    .serial_clock_line_o(scl_o), .serial_clock_line_oe_n(scl_oe_n), .serial_data_line_i(sda_m),
    .serial_data_line_o(sda_o), .serial_data_line_oe_n(sda_oe_n), .bus_alert_input,
    .slv_addr(7'h2a), .sleep_deep, .slv_scl_i(s_scl), .slv_sda_i(sda_s), .slv_sda_o(slv_o),
    .slv_sda_oe_n, .slv_match, .slv_wake);
  tw_peer_model peer_u (.scl(scl_oe_n), .sda(sda_m), .ack_bytes, .sda_oe_n(p_oe_n),
    .first_byte, .stops);

  initial
    forever #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    n_nak += (mst_nak === 1'h1);
    n_rdy += (tx_ready === 1'h1);
    n_wake += (slv_wake === 1'h1);
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic go(input logic [6:0] a, input logic [7:0] c);
    mst_enable = 1'h1;
    cyc(1);
    mst_enable = 1'h0;
    mst_go = 1'h1;
    mst_addr = a;
    mst_count = c;
    cyc(1);
    mst_go = 1'h0;
    cyc(1);
    check("idle after go", 1'h0, master_idle_flag);
  endtask
  task automatic wait_idle(input int n);
    for (int i = 0; i < n && master_idle_flag !== 1'h1; i++)
      cyc(1);
    cyc(2);
    check("idle reached", 1'h1, master_idle_flag);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_write();
    int s0, r0, k0;
    s0 = stops;
    r0 = n_rdy;
    k0 = n_nak;
    ack_bytes = 8'h08;
    tx_valid = 1'h0;
    go(7'h55, 8'h02);
    cyc(6000);
    check("clock held for data", 1'h0, scl_oe_n);
    check("no fetch while invalid", 0, n_rdy - r0);
    tx_valid = 1'h1;
    wait_idle(20000);
    check("address byte", 8'haa, first_byte);
    check("data fetches", 2, n_rdy - r0);
    check("nak count", 0, n_nak - k0);
    check("stop count", 1, stops - s0);
    $display("test write done");
  endtask
  task automatic t_nak();
    int s0, k0;
    s0 = stops;
    k0 = n_nak;
    ack_bytes = 8'h01;
    go(7'h12, 8'h03);
    wait_idle(12000);
    check("nak count", 1, n_nak - k0);
    check("stop before idle", 0, stops - s0);
    cyc(1000); // two clock periods before any disable
    check("stop after nak", 1, stops - s0);
    check("clock released", 1'h1, scl_oe_n);
    ack_bytes = 8'h00;
    go(7'h12, 8'h00);
    wait_idle(8000);
    check("nak count no bytes left", 2, n_nak - k0);
    check("stop before late idle", 2, stops - s0);
    $display("test nak done");
  endtask
  task automatic t_disable();
    go(7'h33, 8'h01);
    cyc(300);
    check("start held", 1'h0, sda_oe_n);
    master_disable_bit = 1'h1;
    cyc(1);
    master_disable_bit = 1'h0;
    cyc(1);
    check("clock released", 1'h1, scl_oe_n);
    check("data released", 1'h1, sda_oe_n);
    check("idle on disable", 1'h1, master_idle_flag);
    $display("test disable done");
  endtask
  task automatic t_alert();
    bus_alert_input = 1'h1; // lone master, no inverter fitted
    cyc(4);
    check("alert high", 1'h1, mst_alert);
    bus_alert_input = 1'h0;
    cyc(4);
    check("alert low", 1'h0, mst_alert);
    $display("test alert done");
  endtask
  task automatic frame(input logic [6:0] a, input logic deep, input logic ack);
    int w0;
    w0 = n_wake;
    s_sda = 1'h0;
    cyc(4);
    sleep_deep = deep; // deep sleep right after Start
    for (int i = 7; i >= 0; i--)
    begin
      s_scl = 1'h0;
      cyc(2);
      s_sda = (i == 0) ? 1'h0 : a[i - 1];
      cyc(2);
      s_scl = 1'h1;
      cyc(4);
    end
    s_scl = 1'h0;
    cyc(2);
    s_sda = 1'h1;
    cyc(2);
    s_scl = 1'h1;
    cyc(4);
    check("slave answer", !ack, sda_s);
    check("slave match", ack, slv_match);
    check("wake count", ack, n_wake - w0);
    s_scl = 1'h0;
    cyc(4);
    s_sda = 1'h0;
    cyc(2);
    s_scl = 1'h1;
    cyc(2);
    s_sda = 1'h1;
    sleep_deep = 1'h0;
    cyc(4);
  endtask

  initial
  begin
    cyc(6);
    check("reset idle", 1'h1, master_idle_flag);
    check("reset lines", 3'h7, {scl_oe_n, sda_oe_n, slv_sda_oe_n});
    check("pin levels", 3'h0, {scl_o, sda_o, slv_o});
    arst_n = 1'h1;
    cyc(2);
    t_write();
    t_nak();
    t_disable();
    t_alert();
    frame(7'h2a, 1'h0, 1'h1);
    frame(7'h2a, 1'h1, 1'h0);
    frame(7'h2b, 1'h0, 1'h0);
    $display("test slave done");
    stop_test();
  end
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
